// [flag_cell.sv]
// Bank of sticky write-one-to-clear event flags.
// Assumes clear pulses come from decoded register writes.
`timescale 1ns/1ns
module flag_cell #(
  parameter int N = 1
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [N-1:0] set,
  input  wire logic [N-1:0] clr,
  input  wire logic [N-1:0] hold,
  input  wire logic         wipe,
  output logic      [N-1:0] flag_q
);
  logic [N-1:0] flag_d;

  // Set beats clear; a live condition blocks clear; zeros clear nothing
  assign flag_d = wipe ? '0 : (set | (flag_q & ~(clr & ~hold)));

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flag_q <= '0;
    end else begin
      flag_q <= flag_d;
    end
  end
endmodule : flag_cell

// [in_sync.sv]
// Three-stage synchroniser with agreement filter for comparator inputs.
// Assumes inputs are slow levels from the analogue side.
`timescale 1ns/1ns
module in_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] level_q
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] level_d;

  // A change counts only once stages two and three agree
  assign level_d = (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & level_q);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1_q    <= '0;
      s2_q    <= '0;
      s3_q    <= '0;
      level_q <= '0;
    end else begin
      s1_q    <= async_in;
      s2_q    <= s1_q;
      s3_q    <= s2_q;
      level_q <= level_d;
    end
  end
endmodule : in_sync

// [pmic_event_and_power_good_logic.sv]
// Event flags, interrupt pin and power-good output of the power manager.
// Assumes synchronous rail enables and pulse inputs; comparators are async.
//
// Local design decisions: the address map and the Wishbone register port.
`timescale 1ns/1ns
module pmic_event_and_power_good_logic #(
  parameter int GATE_CYCLES = pmic_evt_pkg::GATE_CYCLES_DFLT
) (
  input  wire logic                          clk,
  input  wire logic                          rstn,
  input  wire logic                          wb_cyc,
  input  wire logic                          wb_stb,
  input  wire logic                          wb_we,
  input  wire logic [pmic_evt_pkg::AW-1:0]   wb_adr,
  input  wire logic [3:0]                    wb_sel,
  input  wire logic [31:0]                   wb_dat_w,
  output logic      [31:0]                   wb_dat_r,
  output logic                               wb_ack,
  input  wire logic                          temp_warn_det,
  input  wire logic                          temp_sd_det,
  input  wire logic                          ovp_det,
  input  wire logic                          sync_clk_det,
  input  wire logic [pmic_evt_pkg::NRAIL-1:0] rail_uv_ok,
  input  wire logic [pmic_evt_pkg::NRAIL-1:0] rail_ov_ok,
  input  wire logic [pmic_evt_pkg::NRAIL-1:0] rail_enabled,
  input  wire logic                          volt_change,
  input  wire logic                          meas_done,
  input  wire logic                          gp_seq_a,
  input  wire logic                          gp_seq_b,
  input  wire logic                          otp_gating_select,
  input  wire logic                          otp_reset_mask,
  output logic                               irq_n,
  output logic                               power_ok_output,
  output logic                               power_ok_oe,
  output logic                               regs_off,
  output logic                               gp_output_a,
  output logic                               gp_output_b
);
  localparam int NR = pmic_evt_pkg::NRAIL;
  localparam int NT = pmic_evt_pkg::NTOP;
  localparam int GW = $clog2(GATE_CYCLES + 1);
  localparam logic [GW-1:0] GATE_LOAD = GW'(GATE_CYCLES);

  // ==========================================================
  // Input synchronisers
  logic [pmic_evt_pkg::NDET-1:0] det_s;
  in_sync #(
    .W(pmic_evt_pkg::NDET)
  ) u_sync (
    .clk     (clk),
    .rstn    (rstn),
    .async_in({sync_clk_det, ovp_det, temp_sd_det, temp_warn_det, rail_ov_ok, rail_uv_ok}),
    .level_q (det_s)
  );
  wire [NR-1:0] uv_s   = det_s[NR-1:0];
  wire [NR-1:0] ov_s   = det_s[2*NR-1:NR];
  wire          warn_s = det_s[2*NR];
  wire          sd_s   = det_s[2*NR+1];
  wire          ovp_s  = det_s[2*NR+2];
  wire          clk_s  = det_s[2*NR+3];

  // ==========================================================
  // State
  pmic_evt_pkg::seq_state_t state_q;
  pmic_evt_pkg::seq_state_t state_d;
  logic [15:0]   mask_q;
  logic [15:0]   pgctl_q;
  logic [15:0]   ctrl_q;
  logic          gating_q;
  logic          rst_mask_q;
  logic [GW-1:0] gate_q;
  logic [GW-1:0] gate_d;
  logic          pg_q;
  logic          pg_d;
  logic [NR-1:0] good_q;
  logic          warn_q;
  logic          sd_q;
  logic          ovp_q;
  logic          clk_q;
  logic          ack_q;
  logic [31:0]   dat_q;
  logic          irq_n_q;
  logic          pin_q;
  logic          oe_q;
  logic          off_q;
  logic          gpa_q;
  logic          gpb_q;
  logic [pmic_evt_pkg::NFLAG-1:0] fl_q;

  // ==========================================================
  // Bus decode
  wire req      = wb_cyc & wb_stb;
  wire wr_lo    = req & wb_we & ack_q & wb_sel[0];
  wire wr_hi    = req & wb_we & ack_q & wb_sel[1];
  wire hit_flag = wb_adr == pmic_evt_pkg::OFF_FLAG;
  wire hit_railf = wb_adr == pmic_evt_pkg::OFF_RAILF;
  wire hit_mask = wb_adr == pmic_evt_pkg::OFF_MASK;
  wire hit_state = wb_adr == pmic_evt_pkg::OFF_STATE;
  wire hit_pgctl = wb_adr == pmic_evt_pkg::OFF_PGCTL;
  wire hit_ctrl = wb_adr == pmic_evt_pkg::OFF_CTRL;
  wire sw_rst   = wr_lo & hit_ctrl & wb_dat_w[pmic_evt_pkg::CB_SWRST];
  wire cfg_wipe = state_q == pmic_evt_pkg::st_shut;
  wire [15:0] wdat = wb_dat_w[15:0];

  // ==========================================================
  // Configuration fields
  wire [NR-1:0] win        = pgctl_q[pmic_evt_pkg::PB_WIN +: NR];
  wire [NR-1:0] rail_sel   = pgctl_q[pmic_evt_pkg::PB_RSEL +: NR];
  wire [1:0] buck_ok_monitor_select   = rail_sel[1:0];
  wire [1:0] linreg_ok_monitor_select = rail_sel[3:2];
  wire temp_warning_monitor_select = pgctl_q[pmic_evt_pkg::PB_TWSEL];
  wire power_ok_polarity   = pgctl_q[pmic_evt_pkg::PB_POL];
  wire power_ok_open_drain = pgctl_q[pmic_evt_pkg::PB_OD];
  wire clkdet_en = ctrl_q[pmic_evt_pkg::CB_CLKDET];
  wire dual      = ctrl_q[pmic_evt_pkg::CB_DUAL];

  // ==========================================================
  // Rail monitoring and power-good combination
  wire [NR-1:0] good = uv_s & (~win | ov_s);
  wire [NR-1:0] slave_cut = dual ? pmic_evt_pkg::SLAVE_VEC : '0;
  wire [NR-1:0] sel_eff = {linreg_ok_monitor_select, buck_ok_monitor_select}
                          & ~slave_cut
                          & rail_enabled;
  wire rails_ok = &(~sel_eff | good);
  wire twarn_bad = temp_warning_monitor_select & warn_s;
  wire all_ok = rails_ok & ~twarn_bad & ~fl_q[pmic_evt_pkg::FB_OVP]
                & ~fl_q[pmic_evt_pkg::FB_SD];

  wire gate_start = (state_q == pmic_evt_pkg::st_load) | volt_change;
  wire gate_busy  = gate_q != '0;
  assign gate_d = gate_start ? GATE_LOAD : (gate_busy ? gate_q - 1'b1 : gate_q);
  // Gated mode freezes the state while the timer runs, continuous follows at once
  assign pg_d = (gating_q & gate_busy) ? pg_q : all_ok;

  // Polarity only touches the pin; pg_q and the drop flag stay in true sense
  wire lvl_d = power_ok_polarity ? pg_d : ~pg_d;
  wire pin_d = power_ok_open_drain ? 1'b0 : lvl_d;
  wire oe_d  = ~power_ok_open_drain | ~lvl_d;

  // ==========================================================
  // Event flags
  wire clk_evt = clkdet_en & ((clk_s ^ clk_q) | ~clk_s);
  wire [NT-1:0] top_set = {state_q == pmic_evt_pkg::st_load,
                           meas_done,
                           clk_evt,
                           pg_q & ~pg_d,
                           ovp_s & ~ovp_q,
                           sd_s & ~sd_q,
                           warn_s & ~warn_q};
  wire [NT-1:0] top_hold = {4'h0, ovp_s, sd_s, warn_s};
  wire [NT-1:0] top_clr = (wr_lo & hit_flag) ? wb_dat_w[NT-1:0] : '0;
  wire [NR-1:0] rise_set = good & ~good_q;
  wire [NR-1:0] fall_set = ~good & good_q;
  wire [NR-1:0] rail_clr = (wr_lo & hit_railf) ? wb_dat_w[NR-1:0] : '0;

  flag_cell #(
    .N(pmic_evt_pkg::NFLAG)
  ) u_flags (
    .clk   (clk),
    .rstn  (rstn),
    .set   ({fall_set, rise_set, top_set}),
    .clr   ({rail_clr, rail_clr, top_clr}),
    .hold  ({{2*NR{1'b0}}, top_hold}),
    .wipe  (cfg_wipe),
    .flag_q(fl_q)
  );
  wire [NR-1:0] rise_q = fl_q[NT +: NR];
  wire [NR-1:0] fall_q = fl_q[NT+NR +: NR];
  wire [NR-1:0] chg    = rise_q | fall_q;
  wire buck_summary    = |chg[1:0];
  wire linreg_summary  = |chg[3:2];

  // Shutdown and overvoltage have no mask bit
  wire [NT-1:0] top_mask = {rst_mask_q, mask_q[pmic_evt_pkg::FB_MEAS:pmic_evt_pkg::FB_DROP],
                            2'b00, mask_q[pmic_evt_pkg::FB_WARN]};
  wire [NR-1:0] rail_irq = (rise_q & ~mask_q[pmic_evt_pkg::MB_RISE +: NR])
                         | (fall_q & ~mask_q[pmic_evt_pkg::MB_FALL +: NR]);
  wire pending = |(fl_q[NT-1:0] & ~top_mask) | (|rail_irq);

  // Rails stay off while the fault is live or its flag is still set
  wire off_d = (state_d != pmic_evt_pkg::st_run) | sd_s | ovp_s
             | fl_q[pmic_evt_pkg::FB_SD] | fl_q[pmic_evt_pkg::FB_OVP];

  // ==========================================================
  // Read mux
  wire [31:0] rd_flag  = {25'h0, fl_q[NT-1:0]};
  wire [31:0] rd_railf = {26'h0, linreg_summary, buck_summary, chg};
  wire [31:0] rd_mask  = {16'h0, mask_q[15:7], rst_mask_q, mask_q[5:0]};
  wire [31:0] rd_state = {22'h0, gating_q, good, clk_s, pg_q, ovp_s, sd_s, warn_s};
  wire [31:0] rd_data  = hit_flag  ? rd_flag
                       : hit_railf ? rd_railf
                       : hit_mask  ? rd_mask
                       : hit_state ? rd_state
                       : hit_pgctl ? {16'h0, pgctl_q}
                       : hit_ctrl  ? {16'h0, ctrl_q}
                       : 32'h0;

  // ==========================================================
  // Reset sequence: shut down, load stored settings, run
  always_comb begin
    case (state_q)
      pmic_evt_pkg::st_shut: state_d = pmic_evt_pkg::st_load;
      pmic_evt_pkg::st_load: state_d = pmic_evt_pkg::st_run;
      pmic_evt_pkg::st_run:  state_d = sw_rst ? pmic_evt_pkg::st_shut
                                              : pmic_evt_pkg::st_run;
      default:               state_d = pmic_evt_pkg::st_shut;
    endcase
  end

  // Lockout is rstn: everything returns to defaults and starts in the load state, which raises the reset flag
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q    <= pmic_evt_pkg::st_load;
      gating_q   <= 1'b0;
      rst_mask_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (state_q == pmic_evt_pkg::st_load) begin
        gating_q   <= otp_gating_select;
        rst_mask_q <= otp_reset_mask;
      end
    end
  end

  // ==========================================================
  // Software registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mask_q  <= pmic_evt_pkg::MASK_RST;
      pgctl_q <= pmic_evt_pkg::PGCTL_RST;
      ctrl_q  <= pmic_evt_pkg::CTRL_RST;
    end else if (cfg_wipe) begin
      mask_q  <= pmic_evt_pkg::MASK_RST;
      pgctl_q <= pmic_evt_pkg::PGCTL_RST;
      ctrl_q  <= pmic_evt_pkg::CTRL_RST;
    end else begin
      if (wr_lo && hit_mask) mask_q[7:0] <= wdat[7:0] & pmic_evt_pkg::MASK_WR[7:0];
      if (wr_hi && hit_mask) mask_q[15:8] <= wdat[15:8] & pmic_evt_pkg::MASK_WR[15:8];
      if (wr_lo && hit_pgctl) pgctl_q[7:0] <= wdat[7:0] & pmic_evt_pkg::PGCTL_WR[7:0];
      if (wr_hi && hit_pgctl) pgctl_q[15:8] <= wdat[15:8] & pmic_evt_pkg::PGCTL_WR[15:8];
      if (wr_lo && hit_ctrl) ctrl_q[7:0] <= wdat[7:0] & pmic_evt_pkg::CTRL_WR[7:0];
    end
  end

  // ==========================================================
  // Bus answer: ack one cycle after the request, read data with it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0;
    end else begin
      ack_q <= req & ~ack_q;
      if (req && !ack_q) dat_q <= rd_data;
    end
  end

  // ==========================================================
  // Monitors and history
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gate_q <= '0;
      pg_q   <= 1'b1;
      good_q <= '0;
      warn_q <= 1'b0;
      sd_q   <= 1'b0;
      ovp_q  <= 1'b0;
      clk_q  <= 1'b0;
    end else begin
      gate_q <= gate_d;
      pg_q   <= pg_d;
      good_q <= good;
      warn_q <= warn_s;
      sd_q   <= sd_s;
      ovp_q  <= ovp_s;
      clk_q  <= clk_s;
    end
  end

  // ==========================================================
  // Output flops
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_n_q <= 1'b1;
      pin_q   <= 1'b1;
      oe_q    <= 1'b1;
      off_q   <= 1'b1;
      gpa_q   <= 1'b0;
      gpb_q   <= 1'b0;
    end else begin
      irq_n_q <= ~pending;
      pin_q   <= pin_d;
      oe_q    <= oe_d;
      off_q   <= off_d;
      gpa_q   <= gp_seq_a & ~off_d;
      gpb_q   <= gp_seq_b & ~off_d;
    end
  end

  assign wb_ack          = ack_q;
  assign wb_dat_r        = dat_q;
  assign irq_n           = irq_n_q;
  assign power_ok_output = pin_q;
  assign power_ok_oe     = oe_q;
  assign regs_off        = off_q;
  assign gp_output_a     = gpa_q;
  assign gp_output_b     = gpb_q;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  irq_pending_a: assert property (pending |=> !irq_n)
    else $error("unmasked flag did not pull irq low");
  irq_idle_a: assert property (!pending |=> irq_n)
    else $error("irq low with nothing pending");
  warn_hold_a: assert property (warn_s && fl_q[pmic_evt_pkg::FB_WARN] && !cfg_wipe
                                |=> fl_q[pmic_evt_pkg::FB_WARN])
    else $error("warning flag cleared while hot");
  sd_shutdown_a: assert property ($rose(sd_s) |=> regs_off && !gp_output_a
                                  && !gp_output_b && fl_q[pmic_evt_pkg::FB_SD])
    else $error("thermal shutdown not acted on");
  ovp_hold_a: assert property (ovp_s && fl_q[pmic_evt_pkg::FB_OVP] && !cfg_wipe
                               |=> fl_q[pmic_evt_pkg::FB_OVP] && regs_off)
    else $error("overvoltage flag or shutdown lost");
  drop_flag_a: assert property ($fell(pg_q) |-> fl_q[pmic_evt_pkg::FB_DROP])
    else $error("power-good drop not flagged");
  zero_write_a: assert property (wr_lo && hit_flag && !wb_dat_w[pmic_evt_pkg::FB_MEAS]
                                 && fl_q[pmic_evt_pkg::FB_MEAS] && !cfg_wipe
                                 |=> fl_q[pmic_evt_pkg::FB_MEAS])
    else $error("zero write cleared a flag");
  reset_flag_a: assert property (sw_rst |=> ##1 state_q == pmic_evt_pkg::st_load
                                 ##1 fl_q[pmic_evt_pkg::FB_RST])
    else $error("software reset did not raise reset flag");
  ovp_pg_a: assert property (fl_q[pmic_evt_pkg::FB_OVP] && !(gating_q && gate_busy)
                             |=> !pg_q)
    else $error("power-good active with overvoltage");
  gate_hold_a: assert property (gating_q && gate_busy |=> $stable(pg_q))
    else $error("power-good moved inside gating period");
  cont_track_a: assert property (!gating_q && !cfg_wipe |=> pg_q == $past(all_ok))
    else $error("continuous mode did not track");
  pin_pol_a: assert property (!power_ok_open_drain |=>
                              power_ok_output == ($past(power_ok_polarity) ? pg_q : !pg_q))
    else $error("pin level wrong for polarity");
  ack_once_a: assert property (wb_ack |=> !wb_ack)
    else $error("ack held for two cycles");

  irq_seen_c: cover property (pending ##1 !irq_n);
  pg_drop_c:  cover property ($fell(pg_q));
  sw_rst_c:   cover property (sw_rst ##3 fl_q[pmic_evt_pkg::FB_RST]);
endmodule : pmic_event_and_power_good_logic

// [pmic_event_and_power_good_logic_tb.sv]
// Self-checking bench for the event flags, interrupt pin and power-good pin.
// Assumes comparator inputs settle through the synchroniser within 8 cycles.
`timescale 1ns/1ns
module pmic_event_and_power_good_logic_tb;
  logic        clk = 1'b0, rstn = 1'b0, md = 1'b0, ckd = 1'b1;
  logic        twd = 1'b0, sdd = 1'b0, ovd = 1'b0, vc = 1'b0, gsel = 1'b0;
  logic        cyc, stb, we, ack, irq_n, pok, poe, roff, ga, gb;
  logic [7:0]  adr;
  logic [31:0] dw, dr, q, x = 32'hed36;
  logic [3:0]  uv = 4'hf, ov = 4'hf, en = 4'hf, sel;
  int          n_mismatch = 0, tests_run = 0, cnt = 0;
  always #50 clk = ~clk;
  wb_host host (.clk(clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .dat_w(dw),
    .dat_r(dr), .ack(ack), .sel(sel));
  pmic_event_and_power_good_logic #(.GATE_CYCLES(20)) dut (.clk(clk), .rstn(rstn),
    .wb_cyc(cyc), .wb_stb(stb), .wb_we(we), .wb_adr(adr), .wb_sel(sel), .wb_dat_w(dw),
    .wb_dat_r(dr), .wb_ack(ack), .temp_warn_det(twd), .temp_sd_det(sdd), .ovp_det(ovd),
    .sync_clk_det(ckd), .rail_uv_ok(uv), .rail_ov_ok(ov), .rail_enabled(en),
    .volt_change(vc), .meas_done(md), .gp_seq_a(1'b1), .gp_seq_b(1'b1),
    .otp_gating_select(gsel), .otp_reset_mask(1'b0), .irq_n(irq_n),
    .power_ok_output(pok), .power_ok_oe(poe), .regs_off(roff), .gp_output_a(ga),
    .gp_output_b(gb));
  // ==========================================
  // Helpers
  task summarize;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize
  task ck(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : ck
  task w(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q);
  endtask : w
  task rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    host.xfer(1'b0, a, 32'h0, q);
    ck($sformatf("reg %h", a), e, q & m);
  endtask : rc
  task wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs
  // Own change flag plus the buck or linreg summary bit
  function automatic logic [31:0] rail_exp(input int i);
    return (32'h1 << i) | ((i < 2) ? 32'h10 : 32'h20);
  endfunction : rail_exp
  always @(posedge clk) begin
    cnt <= cnt + 1;
    if (cnt == 30000) begin
      n_mismatch++;
      summarize();
    end
  end
  // ==========================================
  // Scenarios
  initial begin
    wt(8);
    rstn <= 1'b1;
    wt(4);
    rc(8'h00, 32'h40, 32'h40);
    ck("irq_n", 1'b0, irq_n);
    w(8'h00, 32'h0);
    rc(8'h00, 32'h40, 32'h40);
    w(8'h00, 32'hffff);
    w(8'h04, 32'hf);
    wt(2);
    rc(8'h00, 32'hffff, 32'h0);
    ck("irq_n", 1'b1, irq_n);
    rc(8'h20, 32'hffffffff, 32'h0);
    repeat (4) begin
      x = xs(x);
      w(8'h08, x & 32'hff39);
      rc(8'h08, 32'hffff, x & 32'hff39);
    end
    w(8'h08, 32'h0);
    $display("test registers done");
    md <= 1'b1;
    wt(1);
    md <= 1'b0;
    wt(3);
    rc(8'h00, 32'hffff, 32'h20);
    ck("irq_n", 1'b0, irq_n);
    w(8'h08, 32'h20);
    wt(2);
    ck("irq_n", 1'b1, irq_n);
    w(8'h00, 32'h20);
    w(8'h08, 32'h0);
    twd <= 1'b1;
    wt(8);
    w(8'h00, 32'h1);
    rc(8'h00, 32'h1, 32'h1);
    ck("regs_off", 1'b0, roff);
    w(8'h10, 32'h21f);
    wt(3);
    rc(8'h0c, 32'h9, 32'h1);
    rc(8'h00, 32'h8, 32'h8);
    twd <= 1'b0;
    w(8'h10, 32'h20f);
    wt(8);
    w(8'h00, 32'hffff);
    rc(8'h00, 32'hffff, 32'h0);
    $display("test events done");
    for (int i = 0; i < 4; i++) begin
      uv[i] <= 1'b0;
      wt(8);
      rc(8'h04, 32'h3f, rail_exp(i));
      rc(8'h0c, 32'h8, 32'h0);
      ck("power_ok_output", 1'b0, pok);
      en[i] <= 1'b0;
      wt(3);
      rc(8'h0c, 32'h8, 32'h8);
      en[i] <= 1'b1;
      uv[i] <= 1'b1;
      wt(8);
      w(8'h04, 32'hf);
      w(8'h00, 32'hffff);
    end
    ov[0] <= 1'b0;
    wt(8);
    rc(8'h0c, 32'h8, 32'h8);
    w(8'h10, 32'h22f);
    wt(3);
    rc(8'h0c, 32'h8, 32'h0);
    w(8'h10, 32'h00f);
    ov[0] <= 1'b1;
    wt(8);
    ck("power_ok_output", 1'b0, pok);
    rc(8'h0c, 32'h8, 32'h8);
    w(8'h10, 32'h60f);
    wt(3);
    ck("power_ok_oe", 1'b0, poe);
    w(8'h10, 32'h20f);
    w(8'h04, 32'hf);
    w(8'h00, 32'hffff);
    $display("test power good done");
    for (int k = 0; k < 2; k++) begin
      sdd <= (k == 0);
      ovd <= (k == 1);
      wt(8);
      ck("regs_off gp", 3'b100, {roff, ga, gb});
      w(8'h00, 32'h6);
      rc(8'h00, 32'h6, 32'h2 << k);
      sdd <= 1'b0;
      ovd <= 1'b0;
      wt(8);
      w(8'h00, 32'hffff);
      rc(8'h00, 32'h6, 32'h0);
    end
    ckd <= 1'b0;
    w(8'h14, 32'h2);
    wt(8);
    w(8'h00, 32'h10);
    rc(8'h00, 32'h10, 32'h10);
    ckd <= 1'b1;
    wt(8);
    w(8'h00, 32'h10);
    rc(8'h0c, 32'h10, 32'h10);
    rc(8'h00, 32'h10, 32'h0);
    gsel <= 1'b1;
    w(8'h14, 32'h1);
    wt(4);
    rc(8'h00, 32'h40, 32'h40);
    rc(8'h14, 32'hffff, 32'h0);
    // Restart loaded gated mode; a rail drop must wait out the gating period
    uv[2] <= 1'b0;
    wt(8);
    rc(8'h0c, 32'h208, 32'h208);
    wt(4);
    rc(8'h0c, 32'h8, 32'h0);
    vc <= 1'b1;
    wt(1);
    vc <= 1'b0;
    uv[2] <= 1'b1;
    wt(8);
    rc(8'h0c, 32'h8, 32'h0);
    wt(12);
    rc(8'h0c, 32'h8, 32'h8);
    $display("test faults done");
    summarize();
  end
endmodule : pmic_event_and_power_good_logic_tb

// [pmic_evt_pkg.sv]
// Constants, field positions and state type of the event and power-good logic.
// Assumes a 10 MHz core clock and a 32-bit classic Wishbone register port.

package pmic_evt_pkg;

  // ==========================================================
  // Sizes and register map
  localparam int NRAIL = 4;
  localparam int NTOP  = 7;
  localparam int NFLAG = NTOP + 2 * NRAIL;
  localparam int NDET  = 2 * NRAIL + 4;
  localparam int AW    = 8;

  localparam logic [7:0] OFF_FLAG  = 8'h00;
  localparam logic [7:0] OFF_RAILF = 8'h04;
  localparam logic [7:0] OFF_MASK  = 8'h08;
  localparam logic [7:0] OFF_STATE = 8'h0c;
  localparam logic [7:0] OFF_PGCTL = 8'h10;
  localparam logic [7:0] OFF_CTRL  = 8'h14;

  // ==========================================================
  // Field positions
  localparam int FB_WARN = 0;
  localparam int FB_SD   = 1;
  localparam int FB_OVP  = 2;
  localparam int FB_DROP = 3;
  localparam int FB_CLK  = 4;
  localparam int FB_MEAS = 5;
  localparam int FB_RST  = 6;
  localparam int MB_RISE = 8;
  localparam int MB_FALL = 12;
  localparam int PB_RSEL  = 0;
  localparam int PB_TWSEL = 4;
  localparam int PB_WIN   = 5;
  localparam int PB_POL   = 9;
  localparam int PB_OD    = 10;
  localparam int CB_SWRST  = 0;
  localparam int CB_CLKDET = 1;
  localparam int CB_DUAL   = 2;

  // ==========================================================
  // Reset values and writable bits
  localparam logic [15:0] MASK_RST  = 16'h0000;
  localparam logic [15:0] MASK_WR   = 16'hffb9;
  localparam logic [15:0] PGCTL_RST = 16'h020f;
  localparam logic [15:0] PGCTL_WR  = 16'h07ff;
  localparam logic [15:0] CTRL_RST  = 16'h0000;
  localparam logic [15:0] CTRL_WR   = 16'h0006;
  localparam logic [NRAIL-1:0] SLAVE_VEC = 4'h2;

  // ==========================================================
  // Timing
  localparam int GATE_TIME_US     = 800;
  localparam int CLK_FREQ_MHZ     = 10;
  localparam int GATE_CYCLES_DFLT = GATE_TIME_US * CLK_FREQ_MHZ;

  typedef enum logic [1:0] {st_shut, st_load, st_run} seq_state_t;

endpackage : pmic_evt_pkg

// [wb_host.sv]
// Register-bus host model standing in for the processor.
// Assumes one clock; the bench cuts any hang short.
`timescale 1ns/1ns
module wb_host (
  input  wire logic        clk,
  output logic             cyc,
  output logic             stb,
  output logic             we,
  output logic [7:0]       adr,
  output logic [3:0]       sel,
  output logic [31:0]      dat_w,
  input  wire logic [31:0] dat_r,
  input  wire logic        ack
);
  // ==========================================
  // Classic single cycle
  initial begin
    cyc   = 1'b0;
    stb   = 1'b0;
    we    = 1'b0;
    adr   = 8'h00;
    sel   = 4'h0;
    dat_w = 32'h0;
  end
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    cyc   <= 1'b1;
    stb   <= 1'b1;
    we    <= w;
    adr   <= a;
    sel   <= 4'hf;
    dat_w <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : xfer
endmodule : wb_host
